// File: dv/virtual_channel_capability_regs_test.sv
// self-checking bench for the channel capability register bank
`timescale 1ns/100ps
`include "vchan_defs.svh"
module virtual_channel_capability_regs_test;
  import vchan_pkg::*;
  logic core_clk, nrst, cfg_rd, cfg_wr, strap, al_valid, entry_wr, load_done;
  logic cfg_rvalid, load_req, grp_valid;
  logic [11:0] cfg_addr;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata;
  logic [2:0] al_ext, al_low, ext_count;
  arb_scheme_e scheme;
  int num_errors = 0;
  int total_checks = 0;
  // behavioural model state
  int m_ext, m_low, m_sel, m_stat, m_busy;
  logic [11:0] ro_addr[3] = '{`OFF_HEADER, `OFF_CAP_ONE, `OFF_CAP_TWO};

  vchan_cap_regs vchan_cap_regs_inst (
    .CORE_CLK(core_clk), .NRST(nrst),
    .CFG_ADDR(cfg_addr), .CFG_RD(cfg_rd), .CFG_WR(cfg_wr), .CFG_BE(cfg_be),
    .CFG_WDATA(cfg_wdata), .CFG_RDATA(cfg_rdata), .CFG_RVALID(cfg_rvalid),
    .EXTRA_CHANNEL_STRAP(strap),
    .AUTOLOAD_VALID(al_valid), .AUTOLOAD_EXT_COUNT(al_ext), .AUTOLOAD_LOW_COUNT(al_low),
    .TABLE_ENTRY_WR(entry_wr), .TABLE_LOAD_DONE(load_done), .LOAD_TABLE_REQ(load_req),
    .ARB_SCHEME(scheme), .LOW_GROUP_ARB_VALID(grp_valid), .EXT_CHANNEL_COUNT(ext_count)
  );

  function automatic logic [31:0] exp_read(logic [11:0] a);
    case (a)
      `OFF_HEADER: exp_read = 32'h20C1_0002;
      `OFF_CAP_ONE: exp_read = {20'h0, 2'h2, 2'h0, 1'h0, 3'(m_low), 1'h0, 3'(m_ext)};
      `OFF_CAP_TWO: exp_read = (m_ext % 2 == 1) ? 32'h0300_0003 : 32'h0;
      `OFF_CTRL_STAT: exp_read = {15'h0, 1'(m_stat), 12'h0, 3'(m_sel), 1'h0};
      default: exp_read = 32'h0;
    endcase
  endfunction : exp_read

  task automatic check(logic [31:0] seen, logic [31:0] exp, string what);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  task automatic read_chk(logic [11:0] a);
    @(negedge core_clk);
    cfg_rd = 1'h1;
    cfg_addr = a;
    @(negedge core_clk);
    cfg_rd = 1'h0;
    check({31'h0, cfg_rvalid}, 32'h1, "read strobe");
    check(cfg_rdata, exp_read(a), "read data");
    @(negedge core_clk);
    // data only qualified by the strobe
    check(cfg_rdata, 32'h0, "read data after strobe");
    check({31'h0, cfg_rvalid}, 32'h0, "read strobe width");
  endtask : read_chk

  task automatic cfg_write(logic [11:0] a, logic [3:0] be, logic [31:0] d);
    logic exp_req;
    exp_req = 1'h0;
    if (a == `OFF_CTRL_STAT && be[0]) begin
      m_sel = d[3:1];
      exp_req = d[0] && m_busy == 0;
      if (exp_req) m_busy = 1;
    end
    @(negedge core_clk);
    cfg_wr = 1'h1;
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = d;
    @(negedge core_clk);
    cfg_wr = 1'h0;
    check({31'h0, load_req}, {31'h0, exp_req}, "load request");
    @(negedge core_clk);
    check({31'h0, load_req}, 32'h0, "load request width");
    check({31'h0, scheme}, (m_sel == 1 && m_low != 0) ? 32'h1 : 32'h0, "scheme");
  endtask : cfg_write

  task automatic table_event(logic wr, logic done);
    @(negedge core_clk);
    entry_wr = wr;
    load_done = done;
    @(negedge core_clk);
    entry_wr = 1'h0;
    load_done = 1'h0;
    // done only counts while a load is outstanding
    if (done && m_busy != 0) begin
      m_busy = 0;
      m_stat = 0;
    end
    if (wr) m_stat = 1;
  endtask : table_event

  task automatic autoload(logic [2:0] e, logic [2:0] l);
    @(negedge core_clk);
    al_valid = 1'h1;
    al_ext = e;
    al_low = l;
    @(negedge core_clk);
    al_valid = 1'h0;
    m_ext = e;
    m_low = l;
    @(negedge core_clk);
    check({29'h0, ext_count}, {29'h0, e}, "extended count output");
    check({31'h0, grp_valid}, (l != 0) ? 32'h1 : 32'h0, "group valid");
  endtask : autoload

  task automatic check_all();
    read_chk(`OFF_HEADER);
    read_chk(`OFF_CAP_ONE);
    read_chk(`OFF_CAP_TWO);
    read_chk(`OFF_CTRL_STAT);
    read_chk(12'h150);
    check({29'h0, ext_count}, 32'(m_ext), "extended count output");
    check({31'h0, grp_valid}, (m_low != 0) ? 32'h1 : 32'h0, "group valid");
  endtask : check_all

  task automatic do_reset(logic s);
    nrst = 1'h0;
    strap = s;
    m_ext = s;
    m_low = 0;
    m_sel = 0;
    m_stat = 0;
    m_busy = 0;
    repeat (4) @(negedge core_clk);
    nrst = 1'h1;
    // strap needs sync plus settle before capture
    repeat (6) @(negedge core_clk);
  endtask : do_reset

  initial begin
    core_clk = 1'h0;
    forever #4 core_clk = ~core_clk;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    $display("watchdog expired at %0t", $time);
    final_report();
  end

  initial begin
    {nrst, cfg_rd, cfg_wr, strap, al_valid, entry_wr, load_done} = 7'h0;
    {cfg_addr, cfg_be, cfg_wdata, al_ext, al_low} = 54'h0;
    void'($urandom(63));
    do_reset(1'($urandom));
    check_all();
    $display("test reset values done");
    foreach (ro_addr[i]) cfg_write(ro_addr[i], 4'hF, 32'hFFFF_FFFF);
    cfg_write(`OFF_HEADER, 4'hF, 32'h0000_0000);
    read_chk(`OFF_HEADER);
    cfg_write(12'h150, 4'hF, 32'hFFFF_FFFF);
    cfg_write(`OFF_CTRL_STAT, 4'hE, 32'hFFFF_FFFF);
    check_all();
    $display("test read-only writes done");
    // every select value, group count zero then nonzero
    for (int i = 0; i < 16; i++) begin
      if (i == 8) autoload(3'(m_ext), 3'h1 + 3'($urandom % 7));
      cfg_write(`OFF_CTRL_STAT, 4'h1, ($urandom & 32'hFFFF_FFF0) | 32'((i % 8) << 1));
      read_chk(`OFF_CTRL_STAT);
    end
    $display("test select values done");
    for (int i = 0; i < 6; i++) begin
      autoload(3'($urandom), (i == 2) ? 3'h0 : 3'($urandom));
      check_all();
    end
    $display("test autoload done");
    table_event(1'h1, 1'h0);
    read_chk(`OFF_CTRL_STAT);
    cfg_write(`OFF_CTRL_STAT, 4'h1, 32'h0000_0003);
    cfg_write(`OFF_CTRL_STAT, 4'h1, 32'h0000_0001);
    read_chk(`OFF_CTRL_STAT);
    table_event(1'h0, 1'h1);
    read_chk(`OFF_CTRL_STAT);
    table_event(1'h1, 1'h0);
    table_event(1'h0, 1'h1);
    read_chk(`OFF_CTRL_STAT);
    cfg_write(`OFF_CTRL_STAT, 4'h1, 32'h0000_0001);
    table_event(1'h0, 1'h1);
    read_chk(`OFF_CTRL_STAT);
    // entry write and load finish together: set wins
    cfg_write(`OFF_CTRL_STAT, 4'h1, 32'h0000_0001);
    table_event(1'h1, 1'h1);
    read_chk(`OFF_CTRL_STAT);
    $display("test table status done");
    // mid-run reset with the other strap level
    do_reset(~strap);
    check_all();
    $display("test second reset done");
    final_report();
  end
endmodule : virtual_channel_capability_regs_test

// File: rtl/table_load_if.sv
// table load command and status between register bank and tracker
`timescale 1ns/100ps
interface table_load_if;
  logic load_cmd;
  logic entry_wr;
  logic load_done;
  logic load_req;
  logic load_busy;
  logic table_pending;
  modport regs (output load_cmd, output entry_wr, output load_done,
                input load_req, input load_busy, input table_pending);
  modport tracker (input load_cmd, input entry_wr, input load_done,
                   output load_req, output load_busy, output table_pending);
endinterface : table_load_if

// File: rtl/table_load_tracker.sv
// arbitration table pending flag and load handshake
`timescale 1ns/100ps
module table_load_tracker (
  input wire logic clk,
  input wire logic nrst,
  table_load_if.tracker tl
);
  import vchan_pkg::*;
  load_state_e state_q;
  assign tl.load_busy = (state_q == LOAD_BUSY);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= LOAD_IDLE;
    end else begin
      case (state_q)
        LOAD_IDLE: if (tl.load_cmd) state_q <= LOAD_BUSY;
        LOAD_BUSY: if (tl.load_done) state_q <= LOAD_IDLE;
        default: state_q <= LOAD_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tl.load_req <= 1'b0;
    end else begin
      tl.load_req <= tl.load_cmd && (state_q == LOAD_IDLE);
    end
  end
  // set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tl.table_pending <= 1'b0;
    end else if (tl.entry_wr) begin
      tl.table_pending <= 1'b1;
    end else if (state_q == LOAD_BUSY && tl.load_done) begin
      tl.table_pending <= 1'b0;
    end
  end
endmodule : table_load_tracker

// File: rtl/two_flop_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/100ps
module two_flop_sync (
  input wire logic clk,
  input wire logic nrst,
  input wire logic d,
  output logic q
);
  logic meta_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : two_flop_sync

// File: rtl/vchan_cap_regs.sv
// virtual channel extended capability register bank
// Function
// - the header's low sixteen bits always read the capability identifier 0002h.
// - header bits 19:16 always read capability version 1h.
// - header bits 31:20 read the next pointer 20Ch and cannot be written.
// - the extended count resets to 00b above the captured strap level; autoload may replace it.
// - the low-priority group count in bits 6:4 resets to 000b and only autoload changes it.
// - the reference clock field reads 00b, meaning a 100 ns period.
// - the table entry size field in bits 11:10 always reads 10b.
// - the arbitration capability reads 03h when the count's low bit is one, else 00h.
// - the arbitration capability is used only while the low-priority group count is nonzero.
// - the arbitration table offset reads 03h sixteen-byte units when the low bit is one, else 00h.
// - writing one to the load bit starts a table load unless one is already in progress; the bit resets to and reads as zero.
// - the select field reads back any value written, selects schemes 0 and 1, drives the default scheme for any other value, resets to 0.
// - a software write to any table entry sets the status bit at position 16.
// - the status bit clears when hardware finishes the load that the load bit started, unless a table entry write comes in the same cycle.
`timescale 1ns/100ps
`include "vchan_defs.svh"
module vchan_cap_regs (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic NRST,
  // configuration access
  input wire logic [11:0] CFG_ADDR,
  input wire logic CFG_RD,
  input wire logic CFG_WR,
  input wire logic [3:0] CFG_BE,
  input wire logic [31:0] CFG_WDATA,
  output logic [31:0] CFG_RDATA,
  output logic CFG_RVALID,
  // strap pin
  input wire logic EXTRA_CHANNEL_STRAP,
  // serial autoload
  input wire logic AUTOLOAD_VALID,
  input wire logic [2:0] AUTOLOAD_EXT_COUNT,
  input wire logic [2:0] AUTOLOAD_LOW_COUNT,
  // arbitration table
  input wire logic TABLE_ENTRY_WR,
  input wire logic TABLE_LOAD_DONE,
  output logic LOAD_TABLE_REQ,
  // arbitration setup
  output vchan_pkg::arb_scheme_e ARB_SCHEME,
  output logic LOW_GROUP_ARB_VALID,
  output logic [2:0] EXT_CHANNEL_COUNT
);
  import vchan_pkg::*;

  table_load_if tl ();

  logic [11:0] word_addr;
  logic hit_header;
  logic hit_cap_one;
  logic hit_cap_two;
  logic hit_ctrl;
  logic ctrl_wr;
  logic strap_s;
  logic [1:0] settle_q;
  logic strap_done_q;
  logic autoload_seen_q;
  logic [2:0] ext_count_q;
  logic [2:0] low_count_q;
  logic [2:0] arb_sel_q;
  logic [31:0] rd_word;
  logic [31:0] header_word;
  logic [31:0] cap_one_word;
  logic [31:0] cap_two_word;
  logic [31:0] ctrl_stat_word;
  logic [7:0] arb_cap;
  logic [7:0] arb_tbl_off;

  assign word_addr = {CFG_ADDR[11:2], 2'b00};
  assign hit_header = (word_addr == `OFF_HEADER);
  assign hit_cap_one = (word_addr == `OFF_CAP_ONE);
  assign hit_cap_two = (word_addr == `OFF_CAP_TWO);
  assign hit_ctrl = (word_addr == `OFF_CTRL_STAT);
  // control sits in byte lane 0 only
  assign ctrl_wr = CFG_WR && hit_ctrl && CFG_BE[0];

  // strap crosses in from a pin
  two_flop_sync u_strap_sync (
    .clk(CORE_CLK),
    .nrst(NRST),
    .d(EXTRA_CHANNEL_STRAP),
    .q(strap_s)
  );

  // wait for the synchroniser to fill before trusting the strap
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      settle_q <= 2'h0;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      if (settle_q == `STRAP_SETTLE) begin
        strap_done_q <= 1'b1;
      end else begin
        settle_q <= settle_q + 2'h1;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      autoload_seen_q <= 1'b0;
    end else if (AUTOLOAD_VALID) begin
      autoload_seen_q <= 1'b1;
    end
  end

  // autoload wins over a late strap capture, so a fast loader is never undone
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      ext_count_q <= {`EXT_HI_RST, 1'b0};
    end else if (AUTOLOAD_VALID) begin
      ext_count_q <= AUTOLOAD_EXT_COUNT;
    end else if (!strap_done_q && settle_q == `STRAP_SETTLE && !autoload_seen_q) begin
      ext_count_q <= {`EXT_HI_RST, strap_s};
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      low_count_q <= `LOW_COUNT_RST;
    end else if (AUTOLOAD_VALID) begin
      low_count_q <= AUTOLOAD_LOW_COUNT;
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      arb_sel_q <= `ARB_SEL_RST;
    end else if (ctrl_wr) begin
      arb_sel_q <= CFG_WDATA[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
    end
  end

  assign tl.load_cmd = ctrl_wr && CFG_WDATA[`CTRL_LOAD_BIT];
  assign tl.entry_wr = TABLE_ENTRY_WR;
  assign tl.load_done = TABLE_LOAD_DONE;

  table_load_tracker u_tracker (
    .clk(CORE_CLK),
    .nrst(NRST),
    .tl(tl)
  );

  assign LOAD_TABLE_REQ = tl.load_req;

  assign arb_cap = ext_count_q[0] ? `ARB_CAP_ON : `ARB_CAP_OFF;
  assign arb_tbl_off = ext_count_q[0] ? `ARB_TBL_ON : `ARB_TBL_OFF;

  assign header_word = {`NEXT_PTR, `CAP_VERSION, `CAP_ID};
  assign cap_one_word = {20'h00000, `ENTRY_SIZE, `REF_CLK_ENC, 1'b0, low_count_q,
                         1'b0, ext_count_q};
  assign cap_two_word = {arb_tbl_off, 16'h0000, arb_cap};
  assign ctrl_stat_word = {15'h0000, tl.table_pending, 12'h000, arb_sel_q, 1'b0};

  always_comb begin
    rd_word = 32'h00000000;
    if (hit_header) begin
      rd_word = header_word;
    end else if (hit_cap_one) begin
      rd_word = cap_one_word;
    end else if (hit_cap_two) begin
      rd_word = cap_two_word;
    end else if (hit_ctrl) begin
      rd_word = ctrl_stat_word;
    end
  end

  // read answer one cycle after the request, zero for other offsets
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      CFG_RDATA <= 32'h00000000;
      CFG_RVALID <= 1'b0;
    end else begin
      CFG_RVALID <= CFG_RD;
      CFG_RDATA <= CFG_RD ? rd_word : 32'h00000000;
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      LOW_GROUP_ARB_VALID <= 1'b0;
    end else begin
      LOW_GROUP_ARB_VALID <= (low_count_q != 3'h0);
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      ARB_SCHEME <= SCHEME_HW_FIXED;
    end else if (low_count_q != 3'h0 && arb_sel_q == `ARB_SEL_MAX) begin
      ARB_SCHEME <= SCHEME_WRR32;
    end else begin
      ARB_SCHEME <= SCHEME_HW_FIXED;
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      EXT_CHANNEL_COUNT <= 3'h0;
    end else begin
      EXT_CHANNEL_COUNT <= ext_count_q;
    end
  end

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!NRST);

  property p_hdr_id;
    CFG_RD && hit_header |=> CFG_RVALID && CFG_RDATA[15:0] == `CAP_ID;
  endproperty
  a_hdr_id: assert property (p_hdr_id)
    else $error("header id wrong");

  property p_hdr_ver;
    CFG_RD && hit_header |=> CFG_RDATA[19:16] == `CAP_VERSION;
  endproperty
  a_hdr_ver: assert property (p_hdr_ver)
    else $error("header version wrong");

  property p_hdr_next;
    CFG_WR && hit_header ##[1:4] CFG_RD && hit_header |=> CFG_RDATA[31:20] == `NEXT_PTR;
  endproperty
  a_hdr_next: assert property (p_hdr_next)
    else $error("next pointer changed");

  property p_strap_take;
    $rose(strap_done_q) && !autoload_seen_q
      |=> EXT_CHANNEL_COUNT == {`EXT_HI_RST, $past(strap_s, 2)};
  endproperty
  a_strap_take: assert property (p_strap_take)
    else $error("strap not captured into count");

  property p_low_only_autoload;
    !AUTOLOAD_VALID |=> $stable(low_count_q);
  endproperty
  a_low_only_autoload: assert property (p_low_only_autoload)
    else $error("group count moved without autoload");

  property p_cap_one_fixed;
    CFG_RD && hit_cap_one
      |=> CFG_RDATA[11:8] == {`ENTRY_SIZE, `REF_CLK_ENC} && CFG_RDATA[6:4] == $past(low_count_q);
  endproperty
  a_cap_one_fixed: assert property (p_cap_one_fixed)
    else $error("capability one fixed fields wrong");

  property p_ref_clk;
    CFG_RD && hit_cap_one |=> CFG_RDATA[9:8] == `REF_CLK_ENC;
  endproperty
  a_ref_clk: assert property (p_ref_clk)
    else $error("reference clock field wrong");

  property p_arb_cap;
    CFG_RD && hit_cap_two
      |=> CFG_RDATA[7:0] == (EXT_CHANNEL_COUNT[0] ? `ARB_CAP_ON : `ARB_CAP_OFF);
  endproperty
  a_arb_cap: assert property (p_arb_cap)
    else $error("arbitration capability mismatch");

  property p_group_valid;
    AUTOLOAD_VALID ##1 1'b1 |=> LOW_GROUP_ARB_VALID == ($past(AUTOLOAD_LOW_COUNT, 2) != 3'h0);
  endproperty
  a_group_valid: assert property (p_group_valid)
    else $error("group valid does not follow count");

  property p_tbl_off;
    CFG_RD && hit_cap_two
      |=> CFG_RDATA[31:24] == (EXT_CHANNEL_COUNT[0] ? `ARB_TBL_ON : `ARB_TBL_OFF);
  endproperty
  a_tbl_off: assert property (p_tbl_off)
    else $error("table offset mismatch");

  property p_load_pulse;
    tl.load_cmd && !tl.load_busy |=> LOAD_TABLE_REQ ##1 !LOAD_TABLE_REQ;
  endproperty
  a_load_pulse: assert property (p_load_pulse)
    else $error("load request not a single pulse");

  property p_load_reads_zero;
    CFG_RD && hit_ctrl |=> CFG_RDATA[`CTRL_LOAD_BIT] == 1'b0;
  endproperty
  a_load_reads_zero: assert property (p_load_reads_zero)
    else $error("load bit read back as one");

  property p_scheme_default;
    arb_sel_q > `ARB_SEL_MAX |=> ARB_SCHEME == SCHEME_HW_FIXED;
  endproperty
  a_scheme_default: assert property (p_scheme_default)
    else $error("invalid select not defaulted");

  property p_sel_readback;
    CFG_RD && hit_ctrl |=> CFG_RDATA[`CTRL_SEL_MSB:`CTRL_SEL_LSB] == $past(arb_sel_q);
  endproperty
  a_sel_readback: assert property (p_sel_readback)
    else $error("select readback wrong");

  property p_status_set;
    TABLE_ENTRY_WR ##1 !TABLE_LOAD_DONE ##[0:1] CFG_RD && hit_ctrl
      |=> CFG_RDATA[`STAT_TABLE_BIT];
  endproperty
  a_status_set: assert property (p_status_set)
    else $error("table status not set by entry write");

  property p_status_clear;
    tl.load_busy && TABLE_LOAD_DONE && !TABLE_ENTRY_WR |=> !tl.table_pending;
  endproperty
  a_status_clear: assert property (p_status_clear)
    else $error("table status not cleared after load");

  property p_reserved_zero;
    CFG_RD && hit_ctrl |=> CFG_RDATA[31:17] == 15'h0000 && CFG_RDATA[15:4] == 12'h000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved control bits not zero");

  property p_unmapped_zero;
    CFG_RD && !(hit_header || hit_cap_one || hit_cap_two || hit_ctrl)
      |=> CFG_RVALID && CFG_RDATA == 32'h00000000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read not zero");

  c_load_cycle: cover property (
    tl.load_cmd ##[1:20] tl.load_busy && TABLE_LOAD_DONE);
  c_autoload: cover property (AUTOLOAD_VALID && AUTOLOAD_LOW_COUNT != 3'h0);
  c_wrr_select: cover property (ARB_SCHEME == SCHEME_WRR32);
  c_strap_one: cover property ($rose(strap_done_q) && strap_s);
  c_set_clear_race: cover property (
    tl.load_busy && TABLE_LOAD_DONE && TABLE_ENTRY_WR);

endmodule : vchan_cap_regs

// File: rtl/vchan_defs.svh
// offsets, field positions, reset values and counts of the channel capability bank
`ifndef VCHAN_DEFS_SVH
`define VCHAN_DEFS_SVH
`define OFF_HEADER 12'h140
`define OFF_CAP_ONE 12'h144
`define OFF_CAP_TWO 12'h148
`define OFF_CTRL_STAT 12'h14C
`define CAP_ID 16'h0002
`define CAP_VERSION 4'h1
`define NEXT_PTR 12'h20C
`define ENTRY_SIZE 2'h2
`define REF_CLK_ENC 2'h0
`define EXT_HI_RST 2'h0
`define LOW_COUNT_RST 3'h0
`define ARB_CAP_ON 8'h03
`define ARB_CAP_OFF 8'h00
`define ARB_TBL_ON 8'h03
`define ARB_TBL_OFF 8'h00
`define ARB_SEL_RST 3'h0
`define ARB_SEL_MAX 3'h1
`define CTRL_LOAD_BIT 0
`define CTRL_SEL_LSB 1
`define CTRL_SEL_MSB 3
`define STAT_TABLE_BIT 16
`define STRAP_SETTLE 2'h2
`endif

// File: rtl/vchan_pkg.sv
// types shared by the channel capability bank
package vchan_pkg;
  typedef enum logic {SCHEME_HW_FIXED, SCHEME_WRR32} arb_scheme_e;
  typedef enum logic {LOAD_IDLE, LOAD_BUSY} load_state_e;
endpackage : vchan_pkg
